/* design/capture_compare_unit.sv */
/*
 * Two capture/compare arrays of 16 channels each, four reloadable timers, prescaler,
 * interrupt status/enable/clear and an Avalon-MM register slave with one wait state.
 * Assumes pins and count inputs are synchronous to SYS_CLK and the overflow input is a one-cycle pulse.
 */
// Chosen here: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ns
// Functional notes
// [RULE1] Two time bases, each a pair of 16-bit timers with reload registers.
// [RULE2] Timer clock: selectable prescaled system clock or general timer six overflow.
// [RULE3] Primary timer of each array may count external input events.
// [RULE4] Sixteen channels per array, each picks its timer and capture or compare.
// [RULE5] One pin per channel; channels 24 to 27 never drive compare output.
// [RULE6] Capture latches the assigned timer on the pin edge and requests interrupt.
// [RULE7] Capture trigger per channel: rising, falling or both edges.
// [RULE8] Compare channels check their timer continuously and act on equality.
// [RULE9] Mode 0: interrupt on every match, pin untouched.
// [RULE10] Mode 1: pin toggles on every match.
// [RULE11] Mode 2: interrupt on match, at most once per timer period.
// [RULE12] Mode 3: pin high on match, low on timer overflow, once per period.
// [RULE13] Double register: two channels share one pin, either match toggles it.
// [RULE14] Timer overflow reloads from reload register and requests timer interrupt.
// [RULE15] Timer overflow re-arms the once-per-period modes 2 and 3.
module capture_compare_unit (
    input  wire logic                      SYS_CLK,
    input  wire logic                      RST_N,
    input  wire logic [ccu_pkg::ADDR_W-1:0] AV_ADDRESS,
    input  wire logic                      AV_READ,
    input  wire logic                      AV_WRITE,
    input  wire logic [31:0]               AV_WRITEDATA,
    input  wire logic [3:0]                AV_BYTEENABLE,
    output logic      [31:0]               AV_READDATA,
    output logic                           AV_WAITREQUEST,
    input  wire logic                      GENERAL_TIMER_SIX_OVF,
    input  wire logic [1:0]                EXT_COUNT,
    input  wire logic [ccu_pkg::NUM_CH-1:0] CC_PIN_IN,
    output logic      [ccu_pkg::NUM_CH-1:0] CC_PIN_OUT,
    output logic      [ccu_pkg::NUM_CH-1:0] CC_PIN_OE,
    output logic                           IRQ
);
    import ccu_pkg::*;
    typedef struct packed {
        logic                             ack;
        logic [31:0]                      rdata;
        logic [BASE_W-1:0]                base_cnt;
        logic [PRE_W-1:0]                 pre_cnt;
        logic [1:0]                       ext_prev;
        logic [NUM_TIMERS-1:0][TCTL_W-1:0] tctl;
        logic [NUM_CH-1:0][MODE_W-1:0]    cmode;
        logic [NUM_CH-1:0]                stat_ch;
        logic [NUM_TIMERS-1:0]            stat_tm;
        logic [NUM_CH-1:0]                en_ch;
        logic [NUM_TIMERS-1:0]            en_tm;
    } top_s;
    top_s                               s_reg;
    top_s                               s_next;
    logic                               do_wr;
    logic                               base_tick;
    logic [31:0]                        rd;
    logic [NUM_TIMERS-1:0]              t_tick;
    logic [NUM_TIMERS-1:0]              t_vwr;
    logic [NUM_TIMERS-1:0]              t_rwr;
    logic [NUM_TIMERS-1:0]              t_step;
    logic [NUM_TIMERS-1:0]              t_ovf;
    logic [NUM_TIMERS-1:0][TIMER_W-1:0] t_val;
    logic [NUM_TIMERS-1:0][TIMER_W-1:0] t_rel;
    logic [NUM_TIMERS-1:0][TIMER_W-1:0] t_wd;
    logic [NUM_CH-1:0]                  c_wr;
    logic [NUM_CH-1:0]                  c_hit;
    logic [NUM_CH-1:0]                  c_evt;
    logic [NUM_CH-1:0]                  c_pin;
    logic [NUM_CH-1:0]                  c_partner;
    logic [NUM_CH-1:0][TIMER_W-1:0]     c_val;
    logic [NUM_CH-1:0][TIMER_W-1:0]     c_wd;

    // byte-lane merge of write data into an old value
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        merge = (old & ~m) | (wd & m);
    endfunction

    // byte address of the i-th word of a register block
    function automatic logic [ADDR_W-1:0] at(input logic [ADDR_W-1:0] base, input int i);
        at = base + ADDR_W'(i * 4);
    endfunction

    // prescaler, timer clocks, register file and interrupt status
    always_comb
    begin
        logic [PRE_W-1:0] pmask;
        logic [31:0]      clr;
        logic             tk;
        pmask = '0;
        clr = RST_WORD;
        tk = 1'b0;
        s_next = s_reg;
        rd = RST_WORD;
        t_vwr = '0;
        t_rwr = '0;
        t_wd = '0;
        c_wr = '0;
        c_wd = '0;
        do_wr = AV_WRITE && s_reg.ack;
        s_next.ack = (AV_READ || AV_WRITE) && !s_reg.ack;
        // [RULE2] 400 ns base tick then power-of-two prescale
        base_tick = (s_reg.base_cnt == BASE_LAST);
        s_next.base_cnt = base_tick ? '0 : s_reg.base_cnt + 1'b1;
        if (base_tick)
            s_next.pre_cnt = s_reg.pre_cnt + 1'b1;
        s_next.ext_prev = EXT_COUNT;
        for (int t = 0; t < NUM_TIMERS; t++)
        begin
            pmask = PRE_W'((1 << s_reg.tctl[t][TC_SRC-1:0]) - 1);
            case (s_reg.tctl[t][TC_SRC+1:TC_SRC])
                SRC_PRESCALE: tk = base_tick && ((s_reg.pre_cnt & pmask) == pmask);
                SRC_GEN_SIX:  tk = GENERAL_TIMER_SIX_OVF;
                // [RULE3] external events clock primary timers only
                SRC_EXT:      tk = (t % 2 == 0) && EXT_COUNT[t/2] && !s_reg.ext_prev[t/2];
                default:      tk = 1'b0;
            endcase
            t_tick[t] = tk && s_reg.tctl[t][TC_RUN];
            if (AV_ADDRESS == at(OFS_T_VAL, t))
            begin
                rd = {16'h0000, t_val[t]};
                t_vwr[t] = do_wr;
                t_wd[t] = TIMER_W'(merge({16'h0000, t_val[t]}, AV_WRITEDATA, AV_BYTEENABLE));
            end
            if (AV_ADDRESS == at(OFS_T_REL, t))
            begin
                rd = {16'h0000, t_rel[t]};
                t_rwr[t] = do_wr;
                t_wd[t] = TIMER_W'(merge({16'h0000, t_rel[t]}, AV_WRITEDATA, AV_BYTEENABLE));
            end
            if (AV_ADDRESS == at(OFS_T_CTL, t))
            begin
                rd = {26'h0000000, s_reg.tctl[t]};
                if (do_wr)
                    s_next.tctl[t] = TCTL_W'(merge({26'h0000000, s_reg.tctl[t]}, AV_WRITEDATA, AV_BYTEENABLE));
            end
        end
        for (int c = 0; c < NUM_CH; c++)
        begin
            if (AV_ADDRESS == at(OFS_CH_VAL, c))
            begin
                rd = {16'h0000, c_val[c]};
                c_wr[c] = do_wr;
                c_wd[c] = TIMER_W'(merge({16'h0000, c_val[c]}, AV_WRITEDATA, AV_BYTEENABLE));
            end
            // [RULE4] per-channel timer and function select
            if (AV_ADDRESS == at(OFS_CH_MODE, c))
            begin
                rd = {27'h0000000, s_reg.cmode[c]};
                if (do_wr)
                    s_next.cmode[c] = MODE_W'(merge({27'h0000000, s_reg.cmode[c]}, AV_WRITEDATA, AV_BYTEENABLE));
            end
        end
        // sticky status: a new event beats a same-cycle clear
        clr = (do_wr && AV_ADDRESS == OFS_CLR_CH) ? merge(RST_WORD, AV_WRITEDATA, AV_BYTEENABLE) : RST_WORD;
        s_next.stat_ch = (s_reg.stat_ch & ~clr) | c_evt;
        clr = (do_wr && AV_ADDRESS == OFS_CLR_TM) ? merge(RST_WORD, AV_WRITEDATA, AV_BYTEENABLE) : RST_WORD;
        // [RULE14] timer interrupt request
        s_next.stat_tm = (s_reg.stat_tm & ~clr[NUM_TIMERS-1:0]) | t_ovf;
        if (do_wr && AV_ADDRESS == OFS_EN_CH)
            s_next.en_ch = merge(s_reg.en_ch, AV_WRITEDATA, AV_BYTEENABLE);
        if (do_wr && AV_ADDRESS == OFS_EN_TM)
            s_next.en_tm = NUM_TIMERS'(merge({28'h0000000, s_reg.en_tm}, AV_WRITEDATA, AV_BYTEENABLE));
        case (AV_ADDRESS)
            OFS_STAT_CH: rd = s_reg.stat_ch;
            OFS_STAT_TM: rd = {28'h0000000, s_reg.stat_tm};
            OFS_EN_CH:   rd = s_reg.en_ch;
            OFS_EN_TM:   rd = {28'h0000000, s_reg.en_tm};
            OFS_PINS:    rd = c_pin;
            default: ;
        endcase
        // read data captured in the wait cycle
        if (AV_READ && !s_reg.ack)
            s_next.rdata = rd;
    end

    // state register
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    // [RULE1] two pairs of reloadable timers
    for (genvar t = 0; t < NUM_TIMERS; t++)
    begin : g_tmr
        cc_timer #(
            .W       (TIMER_W)
        ) u_tmr (
            .clk     (SYS_CLK),
            .rst_n   (RST_N),
            .tick    (t_tick[t]),
            .val_wr  (t_vwr[t]),
            .rel_wr  (t_rwr[t]),
            .wr_data (t_wd[t]),
            .value   (t_val[t]),
            .reload  (t_rel[t]),
            .step    (t_step[t]),
            .ovf     (t_ovf[t])
        );
    end

    // channels, each on the timer of its own array
    for (genvar c = 0; c < NUM_CH; c++)
    begin : g_ch
        localparam int TP = 2 * (c / CH_PER_ARRAY);
        logic tsel;
        assign tsel = s_reg.cmode[c][MD_TSEL];
        // [RULE13] lower eight drive the shared pin
        if (c % CH_PER_ARRAY < PAIR_OFS)
        begin : g_pair
            assign c_partner[c] = c_hit[c + PAIR_OFS];
        end
        else
        begin : g_solo
            assign c_partner[c] = 1'b0;
        end
        // [RULE5] no compare drive on 24 to 27
        if (c >= NOOUT_LO && c <= NOOUT_HI)
        begin : g_inonly
            assign CC_PIN_OE[c] = 1'b0;
        end
        else
        begin : g_io
            assign CC_PIN_OE[c] = (s_reg.cmode[c][2:0] == MD_CMP1) || (s_reg.cmode[c][2:0] == MD_CMP3);
        end
        // [RULE8] capture and compare engine
        cc_channel #(
            .W           (TIMER_W)
        ) u_ch (
            .clk         (SYS_CLK),
            .rst_n       (RST_N),
            .mode        (s_reg.cmode[c][2:0]),
            .dbl         (s_reg.cmode[c][MD_DBL]),
            .tval        (tsel ? t_val[TP + 1] : t_val[TP]),
            .tstep       (tsel ? t_step[TP + 1] : t_step[TP]),
            .tovf        (tsel ? t_ovf[TP + 1] : t_ovf[TP]),
            .pin_in      (CC_PIN_IN[c]),
            .partner_hit (c_partner[c]),
            .wr_en       (c_wr[c]),
            .wr_data     (c_wd[c]),
            .value       (c_val[c]),
            .pin_out     (c_pin[c]),
            .hit         (c_hit[c]),
            .evt         (c_evt[c])
        );
    end

    // bus and interrupt outputs
    assign AV_READDATA    = s_reg.rdata;
    assign AV_WAITREQUEST = (AV_READ || AV_WRITE) && !s_reg.ack;
    assign CC_PIN_OUT     = c_pin;
    assign IRQ            = (|(s_reg.stat_ch & s_reg.en_ch)) || (|(s_reg.stat_tm & s_reg.en_tm));

    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    chk_bus_one_wait: assert property ((AV_READ || AV_WRITE) && AV_WAITREQUEST |=> !AV_WAITREQUEST)
        else $error("waitrequest held more than one cycle");
    chk_timer_pair: assert property (t_tick[0] |=> t_step[0]) // [RULE1]
        else $error("timer did not advance on tick");
    chk_base_period: assert property (base_tick |=> !base_tick [*8]) // [RULE2]
        else $error("base tick too frequent");
    chk_ext_count: assert property (s_reg.tctl[2] == {1'b1, SRC_EXT, 3'h0} && EXT_COUNT[1] && !s_reg.ext_prev[1]
                                    |=> t_step[2]) // [RULE3]
        else $error("external count edge lost");
    chk_no_drive: assert property (CC_PIN_OE[NOOUT_HI:NOOUT_LO] == '0) // [RULE5]
        else $error("input-only channel drives pin");
    chk_timer_irq: assert property (t_ovf[3] |=> s_reg.stat_tm[3]) // [RULE14]
        else $error("overflow did not set timer status");
endmodule

/* design/cc_channel.sv */
/*
 * One capture/compare channel: value register, capture edge detect, compare modes, pin latch.
 * Assumes tval/tstep/tovf come from the allocated timer, step and ovf aligned with the new count.
 */
`timescale 1ns/1ns
module cc_channel #(
    parameter int W = ccu_pkg::TIMER_W
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [2:0]   mode,
    input  wire logic         dbl,
    input  wire logic [W-1:0] tval,
    input  wire logic         tstep,
    input  wire logic         tovf,
    input  wire logic         pin_in,
    input  wire logic         partner_hit,
    input  wire logic         wr_en,
    input  wire logic [W-1:0] wr_data,
    output logic      [W-1:0] value,
    output logic              pin_out,
    output logic              hit,
    output logic              evt
);
    import ccu_pkg::*;
    typedef struct packed {
        logic [W-1:0] value;
        logic         pin;
        logic         pin_prev;
        logic         armed;
        logic         evt;
    } ch_s;
    ch_s  s_reg;
    ch_s  s_next;
    logic rise;
    logic fall;
    logic cap;
    logic fire;

    // [RULE7] trigger edge select
    assign rise = pin_in & ~s_reg.pin_prev;
    assign fall = ~pin_in & s_reg.pin_prev;
    assign cap  = (mode == MD_CAP_RISE && rise) || (mode == MD_CAP_FALL && fall) ||
                  (mode == MD_CAP_BOTH && (rise || fall));
    // [RULE8] match on each timer change
    assign hit  = mode[2] && tstep && (tval == s_reg.value);
    // [RULE15] overflow re-arms once-only modes
    assign fire = hit && (s_reg.armed || tovf);

    // capture wins over a same-cycle software write
    always_comb
    begin
        s_next = s_reg;
        s_next.pin_prev = pin_in;
        s_next.evt = 1'b0;
        if (wr_en)
            s_next.value = wr_data;
        // [RULE6] latch timer, request interrupt
        if (cap)
        begin
            s_next.value = tval;
            s_next.evt = 1'b1;
        end
        case (mode)
            // [RULE9] interrupt on every match
            MD_CMP0: s_next.evt = hit;
            // [RULE10] toggle on each match
            MD_CMP1:
            begin
                s_next.evt = hit;
                // [RULE13] partner also toggles
                if (hit || (dbl && partner_hit))
                    s_next.pin = ~s_reg.pin;
            end
            // [RULE11] once per period
            MD_CMP2: s_next.evt = fire;
            // [RULE12] set on match, clear on overflow
            MD_CMP3:
            begin
                s_next.evt = fire;
                if (fire)
                    s_next.pin = 1'b1;
                else if (tovf)
                    s_next.pin = 1'b0;
            end
            default: ;
        endcase
        if (fire)
            s_next.armed = 1'b0;
        else if (tovf)
            s_next.armed = 1'b1;
    end

    // state register
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign value   = s_reg.value;
    assign pin_out = s_reg.pin;
    assign evt     = s_reg.evt;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_set3;
        mode == MD_CMP3 && fire;
    endsequence
    sequence s_clr3;
        mode == MD_CMP3 && tovf && !hit;
    endsequence

    chk_capture_latch: assert property (cap |=> evt && value == $past(tval)) // [RULE6]
        else $error("capture did not latch timer");
    chk_fall_ignored: assert property (mode == MD_CAP_RISE && fall && !wr_en |=> !evt && $stable(value)) // [RULE7]
        else $error("rising-only capture fired on falling edge");
    chk_mode0_irq: assert property (mode == MD_CMP0 && hit |=> evt && $stable(pin_out)) // [RULE9]
        else $error("mode 0 match wrong");
    chk_mode1_toggle: assert property (mode == MD_CMP1 && hit |=> evt && pin_out != $past(pin_out)) // [RULE10]
        else $error("mode 1 pin did not toggle");
    chk_mode2_once: assert property (mode == MD_CMP2 && hit && !s_reg.armed && !tovf |=> !evt) // [RULE11]
        else $error("mode 2 fired twice in a period");
    chk_mode3_pin: assert property ((s_set3 |=> pin_out && evt) and (s_clr3 |=> !pin_out)) // [RULE12]
        else $error("mode 3 pin wrong");
    chk_double_toggle: assert property (mode == MD_CMP1 && dbl && partner_hit && !hit
                                        |=> pin_out != $past(pin_out) && !evt) // [RULE13]
        else $error("double register pin did not toggle");
    chk_rearm: assert property (mode[2] && tovf && !hit |=> s_reg.armed) // [RULE15]
        else $error("overflow did not re-arm");
endmodule

/* design/cc_timer.sv */
/*
 * One reloadable up-counting timer of the capture/compare unit.
 * Assumes tick is a one-cycle enable; writes come already byte-merged.
 */
`timescale 1ns/1ns
module cc_timer #(
    parameter int W = ccu_pkg::TIMER_W
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         tick,
    input  wire logic         val_wr,
    input  wire logic         rel_wr,
    input  wire logic [W-1:0] wr_data,
    output logic      [W-1:0] value,
    output logic      [W-1:0] reload,
    output logic              step,
    output logic              ovf
);
    import ccu_pkg::*;
    typedef struct packed {
        logic [W-1:0] count;
        logic [W-1:0] reload;
        logic         step;
        logic         ovf;
    } tmr_s;
    tmr_s s_reg;
    tmr_s s_next;

    // count, reload on overflow; a tick beats a same-cycle value write
    always_comb
    begin
        s_next = s_reg;
        s_next.step = 1'b0;
        s_next.ovf = 1'b0;
        if (rel_wr)
            s_next.reload = wr_data;
        if (tick)
        begin
            s_next.step = 1'b1;
            // [RULE14] reload and flag
            if (&s_reg.count)
            begin
                s_next.count = s_reg.reload;
                s_next.ovf = 1'b1;
            end
            else
                s_next.count = s_reg.count + 1'b1;
        end
        else if (val_wr)
        begin
            s_next.count = wr_data;
            s_next.step = 1'b1;
        end
    end

    // state register
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign value  = s_reg.count;
    assign reload = s_reg.reload;
    assign step   = s_reg.step;
    assign ovf    = s_reg.ovf;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_ovf_reload: assert property (tick && (&s_reg.count) |=> ovf && value == $past(s_reg.reload)) // [RULE14]
        else $error("timer did not reload on overflow");
endmodule

/* include/ccu_pkg.sv */
/*
 * Shared constants, register map and mode encodings of the capture/compare unit.
 * Assumes a 100 MHz system clock and a 32-bit Avalon-MM register slave with byte addresses.
 */
package ccu_pkg;
    localparam int TIMER_W      = 16;
    localparam int NUM_CH       = 32;
    localparam int CH_PER_ARRAY = 16;
    localparam int NUM_TIMERS   = 4;
    localparam int PAIR_OFS     = 8;
    localparam int NOOUT_LO     = 24;
    localparam int NOOUT_HI     = 27;
    localparam int ADDR_W       = 9;
    // prescaler: finest tick period and the derived cycle count
    localparam int CLK_MHZ      = 100;
    localparam int FINEST_NS    = 400;
    localparam int BASE_CYC     = (FINEST_NS * CLK_MHZ + 999) / 1000;
    localparam int BASE_W       = 6;
    localparam int PRE_W        = 8;
    localparam logic [BASE_W-1:0] BASE_LAST = BASE_W'(BASE_CYC - 1);
    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_T_VAL   = 9'h000;
    localparam logic [ADDR_W-1:0] OFS_T_REL   = 9'h010;
    localparam logic [ADDR_W-1:0] OFS_T_CTL   = 9'h020;
    localparam logic [ADDR_W-1:0] OFS_CH_VAL  = 9'h040;
    localparam logic [ADDR_W-1:0] OFS_CH_MODE = 9'h0c0;
    localparam logic [ADDR_W-1:0] OFS_STAT_CH = 9'h140;
    localparam logic [ADDR_W-1:0] OFS_STAT_TM = 9'h144;
    localparam logic [ADDR_W-1:0] OFS_CLR_CH  = 9'h148;
    localparam logic [ADDR_W-1:0] OFS_CLR_TM  = 9'h14c;
    localparam logic [ADDR_W-1:0] OFS_EN_CH   = 9'h150;
    localparam logic [ADDR_W-1:0] OFS_EN_TM   = 9'h154;
    localparam logic [ADDR_W-1:0] OFS_PINS    = 9'h158;
    // timer control fields: [2:0] prescale, [4:3] source, [5] run
    localparam int TCTL_W   = 6;
    localparam int TC_SRC   = 3;
    localparam int TC_RUN   = 5;
    // channel mode fields: [2:0] mode, [3] timer select, [4] double register
    localparam int MODE_W   = 5;
    localparam int MD_TSEL  = 3;
    localparam int MD_DBL   = 4;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    typedef enum logic [2:0] {
        MD_OFF      = 3'h0,
        MD_CAP_RISE = 3'h1,
        MD_CAP_FALL = 3'h2,
        MD_CAP_BOTH = 3'h3,
        MD_CMP0     = 3'h4,
        MD_CMP1     = 3'h5,
        MD_CMP2     = 3'h6,
        MD_CMP3     = 3'h7
    } ch_mode_e;
    typedef enum logic [1:0] {
        SRC_PRESCALE = 2'h0,
        SRC_GEN_SIX  = 2'h1,
        SRC_EXT      = 2'h2,
        SRC_STOP     = 2'h3
    } tsrc_e;
endpackage

/* testbench/capture_compare_unit_tb.sv */
/*
 * Self-checking bench: Avalon-MM accesses, timer ticks, pin edges.
 * Assumes the slave answers through waitrequest; overflow input and count inputs as tick sources.
 */
`timescale 1ns/1ns
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module capture_compare_unit_tb;
    import ccu_pkg::*;
    logic        clk = 0;
    logic        rst_n = 0;
    logic [8:0]  adr = '0;
    logic        rd_s = 0;
    logic        wr_s = 0;
    logic [31:0] wdat = '0;
    logic [31:0] rdat;
    logic [31:0] q;
    logic        wq;
    logic        ovf = 0;
    logic [31:0] ext = '0;
    logic [1:0]  cnt_in = '0;
    logic [31:0] p_in;
    logic [31:0] p_out;
    logic [31:0] p_oe;
    logic        irq;
    int          n_fail = 0;
    int          checked = 0;
    always #5 clk = ~clk;
    capture_compare_unit i_capture_compare_unit (.SYS_CLK(clk), .RST_N(rst_n), .AV_ADDRESS(adr),
        .AV_READ(rd_s), .AV_WRITE(wr_s), .AV_WRITEDATA(wdat), .AV_BYTEENABLE(4'hf),
        .AV_READDATA(rdat), .AV_WAITREQUEST(wq), .GENERAL_TIMER_SIX_OVF(ovf), .EXT_COUNT(cnt_in),
        .CC_PIN_IN(p_in), .CC_PIN_OUT(p_out), .CC_PIN_OE(p_oe), .IRQ(irq));
    pin_model i_pin_model (.pin_out(p_out), .pin_oe(p_oe), .ext_lvl(ext), .pin_in(p_in));
    // one access: held until waitrequest is sampled low at a rising edge, data taken there
    task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d);
        adr <= a;
        wdat <= d;
        wr_s <= w;
        rd_s <= ~w;
        do @(posedge clk); while (wq !== 1'b0);
        q = rdat;
        rd_s <= 1'b0;
        wr_s <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rc(input logic [8:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(q, e)
    endtask
    // one timer tick from the overflow input
    task automatic tick();
        ovf <= 1'b1;
        @(posedge clk);
        ovf <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        conclude();
    end
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rc(OFS_STAT_CH, 32'h0);
        rc(9'h1fc, 32'h0);
        $display("test reset done");
        bus(1, OFS_T_REL, 32'h1234);
        bus(1, OFS_T_VAL, 32'hfffe);
        bus(1, OFS_T_CTL, 32'h28);
        tick();
        tick();
        rc(OFS_T_VAL, 32'h1234);
        rc(OFS_STAT_TM, 32'h1);
        bus(1, OFS_EN_TM, 32'h1);
        `CHK(irq, 1'b1)
        bus(1, OFS_CLR_TM, 32'h1);
        rc(OFS_STAT_TM, 32'h0);
        `CHK(irq, 1'b0)
        $display("test timer done");
        // channels 0..2: rise, fall, both
        for (int i = 0; i < 3; i++)
            bus(1, OFS_CH_MODE + 9'(4 * i), 32'(i + 1));
        ext <= 32'h7;
        repeat (3) @(posedge clk);
        rc(OFS_STAT_CH, 32'h5);
        rc(OFS_CH_VAL, 32'h1234);
        bus(1, OFS_CLR_CH, 32'h7);
        ext <= 32'h0;
        repeat (3) @(posedge clk);
        rc(OFS_STAT_CH, 32'h6);
        $display("test capture done");
        // channels 4..7 in compare modes 0..3, channel 24 in toggle mode
        for (int i = 4; i < 8; i++)
        begin
            bus(1, OFS_CH_VAL + 9'(4 * i), 32'h1235);
            bus(1, OFS_CH_MODE + 9'(4 * i), 32'(i));
        end
        bus(1, OFS_CH_MODE + 9'(4 * 24), 32'h5);
        bus(1, OFS_CLR_CH, 32'hffffffff);
        bus(1, OFS_T_VAL, 32'hffff);
        tick();
        tick();
        rc(OFS_STAT_CH, 32'hf0);
        rc(OFS_PINS, 32'ha0);
        `CHK(p_out, 32'ha0)
        `CHK(p_oe, 32'ha0)
        bus(1, OFS_CLR_CH, 32'hffffffff);
        bus(1, OFS_T_VAL, 32'h1234);
        tick();
        rc(OFS_STAT_CH, 32'h30);
        rc(OFS_PINS, 32'h80);
        bus(1, OFS_T_VAL, 32'hffff);
        tick();
        rc(OFS_PINS, 32'h0);
        $display("test compare done");
        // timer 2 counts rising edges of its count input
        bus(1, OFS_T_CTL + 9'h8, 32'h30);
        repeat (2)
        begin
            cnt_in <= 2'h2;
            repeat (2) @(posedge clk);
            cnt_in <= 2'h0;
            repeat (2) @(posedge clk);
        end
        rc(OFS_T_VAL + 9'h8, 32'h2);
        $display("test count done");
        conclude();
    end
endmodule

/* testbench/pin_model.sv */
/*
 * Far side of the channel pins: resolves each pin wire level.
 * Assumes the bench gives the external level of undriven pins.
 */
`timescale 1ns/1ns
module pin_model (
    input  wire logic [31:0] pin_out,
    input  wire logic [31:0] pin_oe,
    input  wire logic [31:0] ext_lvl,
    output logic      [31:0] pin_in
);
    // device level where enabled, outside source elsewhere
    assign pin_in = (pin_out & pin_oe) | (ext_lvl & ~pin_oe);
endmodule
